// ### hw/cfeg_pkg.sv
package cfeg_pkg;

	// Outputs zero to four share one gate, output five has its own
	localparam int CFEG_LOW_OUTPUTS = 5;

	// Reset values
	localparam logic CFEG_REF_RST = 1'h0;
	localparam logic CFEG_OSC_RUN_RST = 1'h0;
	localparam logic CFEG_OUT_RST = 1'h0;
	localparam logic CFEG_GATE_RST = 1'h0;

	// Gate synchroniser depth, in clk cycles
	localparam int CFEG_SYNC_STAGES = 2;

	typedef struct packed {
		logic stage1;
		logic stage2;
		logic live;
	} cfeg_gate_state_t;

	typedef struct packed {
		logic ref_level;
		logic osc_run;
		logic [CFEG_LOW_OUTPUTS-1:0] out_low;
		logic out_five;
	} cfeg_state_t;

endpackage

// ### hw/cfeg_gate_if.sv
`timescale 1ns/1ps
interface cfeg_gate_if;
	logic ref_low;
	logic gate_raw;
	logic gate_synced;
	logic gate_live;

	modport ctrl (output ref_low, output gate_raw, input gate_synced, input gate_live);
	modport gate (input ref_low, input gate_raw, output gate_synced, output gate_live);
endinterface

// ### hw/cfeg_gate_sync.sv
`timescale 1ns/1ps
module cfeg_gate_sync
	import cfeg_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	cfeg_gate_if.gate gif
);

	cfeg_gate_state_t st_q;
	cfeg_gate_state_t st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.stage1 = gif.gate_raw;
		st_d.stage2 = st_q.stage1; // RULE4
		// Only act while the reference is low, so no output is cut short
		if (gif.ref_low)
		begin
			st_d.live = st_q.stage2; // RULE9
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q <= '{stage1: CFEG_GATE_RST, stage2: CFEG_GATE_RST, live: CFEG_GATE_RST};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign gif.gate_synced = st_q.stage2;
	assign gif.gate_live = st_q.live;

	property p_live_moves_low;
		@(posedge clk) disable iff (!reset_n)
		(st_q.live != $past(st_q.live)) |-> $past(gif.ref_low);
	endproperty
	a_live_moves_low: assert property (p_live_moves_low) // RULE4
		else $error("Gate changed while reference high");

	property p_level_reaches_sync;
		@(posedge clk) disable iff (!reset_n)
		gif.gate_raw [*3] |-> gif.gate_synced;
	endproperty
	a_level_reaches_sync: assert property (p_level_reaches_sync) // RULE1
		else $error("High gate not seen after two stages");

	property p_low_reaches_sync;
		@(posedge clk) disable iff (!reset_n)
		!gif.gate_raw ##1 !gif.gate_raw |=> !gif.gate_synced;
	endproperty
	a_low_reaches_sync: assert property (p_low_reaches_sync) // RULE1
		else $error("Low gate not seen after two stages");

endmodule

// ### hw/cfeg_top.sv
`timescale 1ns/1ps
// How it works
// (RULE1) Both gate inputs are active high: high runs outputs, low stops them.
// (RULE2) Base variant: master gate low forces all outputs low, oscillator off.
// (RULE3) Secondary gate low holds only output five low.
// (RULE4) Gates are synchronised; outputs stop or start only while already low.
// (RULE5) Controller waits for oscillator stability after raising master gate.
// (RULE6) Alternate variant: master low keeps oscillator and output five on secondary.
// (RULE7) Six outputs derive from one reference with matched register timing.
// (RULE8) Reference is an external clock input or the crystal oscillator.
// (RULE9) Gates sampled during reference low phase so first pulse is full width.
module cfeg_top
	import cfeg_pkg::*;
#(
	parameter bit ALT_VARIANT = 1'b0
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic master_gate_in,
	input wire logic secondary_gate_in,
	input wire logic use_crystal,
	input wire logic reference_osc_in,
	input wire logic ext_clock_in,
	output logic internal_oscillator_en,
	output logic [CFEG_LOW_OUTPUTS-1:0] clock_out_low,
	output logic clock_out_five
);

	cfeg_state_t st_q;
	cfeg_state_t st_d;

	cfeg_gate_if master_if ();
	cfeg_gate_if second_if ();

	// The live gate moves only in the low phase of the reference; the sync stages move every cycle
	assign master_if.ref_low = !st_q.ref_level; // RULE9
	assign second_if.ref_low = !st_q.ref_level; // RULE9
	assign master_if.gate_raw = master_gate_in; // RULE1
	assign second_if.gate_raw = secondary_gate_in; // RULE1

	cfeg_gate_sync u_master_sync (
		.clk(clk),
		.reset_n(reset_n),
		.gif(master_if)
	);

	cfeg_gate_sync u_second_sync (
		.clk(clk),
		.reset_n(reset_n),
		.gif(second_if)
	);

	logic ref_source;
	logic five_enable;

	always_comb
	begin
		st_d = st_q;
		ref_source = use_crystal ? reference_osc_in : ext_clock_in; // RULE8
		// Start on the synced gate, stop only after the live gate drops:
		// cutting the crystal mid-phase would leave a runt on the outputs
		// Limitation: an external reference stuck high keeps it running
		if (ALT_VARIANT)
		begin
			st_d.osc_run = master_if.gate_synced | second_if.gate_synced |
				master_if.gate_live | second_if.gate_live; // RULE6
			five_enable = second_if.gate_live; // RULE6
		end
		else
		begin
			st_d.osc_run = master_if.gate_synced | master_if.gate_live; // RULE2
			five_enable = master_if.gate_live & second_if.gate_live; // RULE3
		end
		// A stopped crystal reads low, which frees the gates to move
		st_d.ref_level = ref_source & (st_q.osc_run | !use_crystal); // RULE8
		st_d.out_low = {CFEG_LOW_OUTPUTS{st_q.ref_level & master_if.gate_live}}; // RULE7
		st_d.out_five = st_q.ref_level & five_enable; // RULE3
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q <= '{ref_level: CFEG_REF_RST, osc_run: CFEG_OSC_RUN_RST,
				out_low: {CFEG_LOW_OUTPUTS{CFEG_OUT_RST}}, out_five: CFEG_OUT_RST};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign internal_oscillator_en = st_q.osc_run;
	assign clock_out_low = st_q.out_low;
	assign clock_out_five = st_q.out_five;

	// Output five needs the same one-flop path as the others to keep skew matched
	property p_master_low_outs;
		@(posedge clk) disable iff (!reset_n)
		!master_if.gate_live |=> (clock_out_low == '0);
	endproperty
	a_master_low_outs: assert property (p_master_low_outs) // RULE2
		else $error("Outputs zero to four not low with master gate off");

	property p_base_osc_off;
		@(posedge clk) disable iff (!reset_n)
		(!ALT_VARIANT && !master_if.gate_synced && !master_if.gate_live)
			|=> !internal_oscillator_en;
	endproperty
	a_base_osc_off: assert property (p_base_osc_off) // RULE2
		else $error("Oscillator running with master gate off");

	property p_five_off;
		@(posedge clk) disable iff (!reset_n)
		!second_if.gate_live |=> !clock_out_five;
	endproperty
	a_five_off: assert property (p_five_off) // RULE3
		else $error("Output five high with secondary gate off");

	property p_alt_five_runs;
		@(posedge clk) disable iff (!reset_n)
		(ALT_VARIANT && second_if.gate_live && st_q.ref_level) |=> clock_out_five;
	endproperty
	a_alt_five_runs: assert property (p_alt_five_runs) // RULE6
		else $error("Output five not following reference in alternate variant");

	property p_alt_osc_on;
		@(posedge clk) disable iff (!reset_n)
		(ALT_VARIANT && second_if.gate_synced) |=> internal_oscillator_en;
	endproperty
	a_alt_osc_on: assert property (p_alt_osc_on) // RULE6
		else $error("Oscillator off with secondary gate on in alternate variant");

	property p_outputs_matched;
		@(posedge clk) disable iff (!reset_n)
		clock_out_low == {CFEG_LOW_OUTPUTS{clock_out_low[0]}};
	endproperty
	a_outputs_matched: assert property (p_outputs_matched) // RULE7
		else $error("Outputs zero to four differ");

	property p_crystal_stopped;
		@(posedge clk) disable iff (!reset_n)
		(use_crystal && !internal_oscillator_en) |=> !st_q.ref_level;
	endproperty
	a_crystal_stopped: assert property (p_crystal_stopped) // RULE8
		else $error("Reference seen from stopped oscillator");

	property p_full_first_pulse;
		@(posedge clk) disable iff (!reset_n)
		$rose(clock_out_low[0]) |-> !$past(st_q.ref_level, 2);
	endproperty
	a_full_first_pulse: assert property (p_full_first_pulse) // RULE9
		else $error("Output rose without a preceding low reference phase");

	property p_base_five_needs_master;
		@(posedge clk) disable iff (!reset_n)
		(!ALT_VARIANT && !master_if.gate_live) |=> !clock_out_five;
	endproperty
	a_base_five_needs_master: assert property (p_base_five_needs_master) // RULE2
		else $error("Output five high with master gate off");

	property p_outs_follow_ref;
		@(posedge clk) disable iff (!reset_n)
		(master_if.gate_live && st_q.ref_level) |=> (clock_out_low == '1);
	endproperty
	a_outs_follow_ref: assert property (p_outs_follow_ref) // RULE7
		else $error("Outputs zero to four not high with reference high");

	property p_outs_low_ref_low;
		@(posedge clk) disable iff (!reset_n)
		!st_q.ref_level |=> ((clock_out_low == '0) && !clock_out_five);
	endproperty
	a_outs_low_ref_low: assert property (p_outs_low_ref_low) // RULE4
		else $error("Output high while reference low");

	property p_five_matches_low;
		@(posedge clk) disable iff (!reset_n)
		(!ALT_VARIANT && second_if.gate_live) |-> (clock_out_five == clock_out_low[0]);
	endproperty
	a_five_matches_low: assert property (p_five_matches_low) // RULE7
		else $error("Output five skewed from outputs zero to four");

	property p_alt_osc_off;
		@(posedge clk) disable iff (!reset_n)
		(ALT_VARIANT && !master_if.gate_synced && !second_if.gate_synced &&
			!master_if.gate_live && !second_if.gate_live) |=> !internal_oscillator_en;
	endproperty
	a_alt_osc_off: assert property (p_alt_osc_off) // RULE6
		else $error("Oscillator running with both gates off in alternate variant");

	property p_base_osc_on;
		@(posedge clk) disable iff (!reset_n)
		(!ALT_VARIANT && master_if.gate_synced) |=> internal_oscillator_en;
	endproperty
	a_base_osc_on: assert property (p_base_osc_on) // RULE1
		else $error("Oscillator off with master gate on");

	property p_osc_holds_live;
		@(posedge clk) disable iff (!reset_n)
		master_if.gate_live |=> internal_oscillator_en;
	endproperty
	a_osc_holds_live: assert property (p_osc_holds_live) // RULE4
		else $error("Oscillator stopped before outputs were gated");

	property p_ext_ref_passes;
		@(posedge clk) disable iff (!reset_n)
		!use_crystal |=> (st_q.ref_level == $past(ext_clock_in));
	endproperty
	a_ext_ref_passes: assert property (p_ext_ref_passes) // RULE8
		else $error("Reference does not follow external clock");

	property p_xtal_ref_passes;
		@(posedge clk) disable iff (!reset_n)
		(use_crystal && internal_oscillator_en) |=> (st_q.ref_level == $past(reference_osc_in));
	endproperty
	a_xtal_ref_passes: assert property (p_xtal_ref_passes) // RULE8
		else $error("Reference does not follow running crystal");

	property p_live_waits_ref;
		@(posedge clk) disable iff (!reset_n)
		st_q.ref_level |=> ($stable(master_if.gate_live) && $stable(second_if.gate_live));
	endproperty
	a_live_waits_ref: assert property (p_live_waits_ref) // RULE9
		else $error("Gate moved while reference high");

	property p_five_full_pulse;
		@(posedge clk) disable iff (!reset_n)
		$rose(clock_out_five) |-> !$past(st_q.ref_level, 2);
	endproperty
	a_five_full_pulse: assert property (p_five_full_pulse) // RULE9
		else $error("Output five rose without a preceding low reference phase");

endmodule

// ### test/cfeg_ctrl_model.sv
`timescale 1ns/1ps
module cfeg_ctrl_model
(
	input wire logic clk,
	input wire logic osc_en,
	output logic master_gate_in,
	output logic secondary_gate_in,
	output logic ext_clock_in,
	output logic reference_osc_in
);
	logic [1:0] div_q = 2'h0;
	logic [1:0] xtal_q = 2'h0;
	int stable_q = 0;
	initial master_gate_in = 1'h0;
	initial secondary_gate_in = 1'h0;
	// Two samples per phase, so a full-width pulse is exactly two cycles
	always @(posedge clk)
	begin
		div_q <= #1 div_q + 2'h1;
		// A starting crystal begins a fresh cycle, it never joins mid-phase
		xtal_q <= #1 osc_en ? xtal_q + 2'h1 : 2'h0;
		stable_q <= osc_en ? stable_q + 1 : 0;
	end
	assign ext_clock_in = div_q[1];
	// Stopped crystal rests low, not at its last level
	assign reference_osc_in = xtal_q[1];
	// Gate levels only; stopping and restarting is the device's job
	task set_gates(input logic m, input logic s);
		@(posedge clk);
		#1;
		master_gate_in = m;
		secondary_gate_in = s;
		// No ready flag, so count clk cycles with the oscillator enabled ourselves
		for (int i = 0; i < 64 && m && stable_q < 8; i++) @(posedge clk);
		repeat (10) @(posedge clk);
	endtask
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb
	import cfeg_pkg::*;
;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic use_crystal = 1'h0;
	logic master_gate_in, secondary_gate_in, ext_clock_in, reference_osc_in;
	logic internal_oscillator_en, clock_out_five, alt_osc, alt_five;
	logic [CFEG_LOW_OUTPUTS-1:0] clock_out_low, alt_low;
	logic [3:0] now_s;
	logic [3:0] prev_q = 4'h0;
	int rises[4];
	int run[4];
	int errors = 0;
	int check_count = 0;
	initial forever #25 clk = ~clk;
	cfeg_ctrl_model i_ctl (.clk, .osc_en(internal_oscillator_en), .master_gate_in,
		.secondary_gate_in, .ext_clock_in, .reference_osc_in);
	cfeg_top i_dut (.clk, .reset_n, .master_gate_in, .secondary_gate_in, .use_crystal,
		.reference_osc_in, .ext_clock_in, .internal_oscillator_en, .clock_out_low,
		.clock_out_five);
	cfeg_top #(.ALT_VARIANT(1'b1)) i_alt (.clk, .reset_n, .master_gate_in,
		.secondary_gate_in, .use_crystal, .reference_osc_in, .ext_clock_in,
		.internal_oscillator_en(alt_osc), .clock_out_low(alt_low), .clock_out_five(alt_five));
	assign now_s = {clock_out_low[0], clock_out_five, alt_low[0], alt_five};
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Every high pulse must span the full source phase
	always @(posedge clk)
	begin
		cmp(32'(clock_out_low), {32{clock_out_low[0]}} & 32'h1f);
		cmp(32'(alt_low), {32{alt_low[0]}} & 32'h1f);
		for (int k = 0; k < 4; k++)
		begin
			if (now_s[k] && !prev_q[k]) rises[k]++;
			if (prev_q[k] && !now_s[k]) cmp(32'(run[k]), 32'h2);
			run[k] = now_s[k] ? run[k] + 1 : 0;
		end
		prev_q = now_s;
	end
	// Forty cycles hold exactly ten source periods
	task run_case(input logic m, input logic s, input logic [31:0] exp, input logic [1:0] osc);
		i_ctl.set_gates(m, s);
		// Off the edge, so the pulse sampler and the count never race
		#1;
		rises = '{default: 0};
		repeat (40) @(posedge clk);
		#1;
		cmp({8'(rises[3]), 8'(rises[2]), 8'(rises[1]), 8'(rises[0])}, exp);
		cmp({30'h0, internal_oscillator_en, alt_osc}, {30'h0, osc});
	endtask
	task t_sleep;
		run_case(1'h0, 1'h0, 32'h0, 2'h0);
	endtask
	task t_xtal;
		use_crystal = 1'h1;
		run_case(1'h1, 1'h1, 32'h0a0a0a0a, 2'h3);
		run_case(1'h0, 1'h0, 32'h0, 2'h0);
		use_crystal = 1'h0;
	endtask
	task t_full;
		run_case(1'h1, 1'h1, 32'h0a0a0a0a, 2'h3);
	endtask
	task t_sec_off;
		run_case(1'h1, 1'h0, 32'h0a000a00, 2'h3);
	endtask
	task t_alt;
		run_case(1'h0, 1'h1, 32'h0000000a, 2'h1);
	endtask
	task close_out;
		$display("errors=%0d check_count=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		reset_n = 1'h1;
		t_sleep();
		t_xtal();
		t_full();
		t_sec_off();
		t_alt();
		t_sleep();
		close_out();
	end
	initial
	begin
		repeat (2000) @(posedge clk);
		errors++;
		close_out();
	end
endmodule
